/* src/ebi_pkg.sv */
// constants, register map and shared types of the external memory bus interface
// assumes an APB slave port with 32-bit data and a single 50 MHz system clock
//
// Operation
// RULE1 - multiplexed mode: address then data on shared lines, upper lines, latch strobe, controls
// RULE2 - separate mode: shared lines carry data only, dedicated 22-bit address, no latch strobe
// RULE3 - system clock is driven out on the clock output pin in both modes
// RULE4 - internal accesses keep every external control signal inactive
// RULE5 - a write to the internal ROM area runs as a full external write
// RULE6 - first chip select for 0000000H-01FFFFFH, second for 0200000H-03FFFFFH, fixed
// RULE7 - width and wait settings are held and applied per chip-select area
// RULE8 - mode register bit 0: 0 multiplexed, 1 separate; other bits read zero
// RULE9 - mode register takes 8-bit and single-bit access; reset value zero
// RULE10 - multiplexed external access takes three clocks plus inserted waits
// RULE11 - separate external access takes two clocks plus inserted waits
// RULE12 - each area width selectable as 8 or 16 bits in the width register
// RULE13 - width register is accessed in 16-bit units and resets to 5555H
// RULE14 - software programs the width register once, before any external access
// RULE15 - software writes ones to bits 14,12,10,8 and zeros to odd bits
// RULE16 - on-chip peripheral accesses always use a 16-bit width
// RULE17 - 8/16/32-bit accesses, little-endian, lowest-addressed part transferred first
// RULE18 - halfword and word accepted at any address; unaligned ones split up
// RULE19 - halfword at odd address becomes two byte cycles
// RULE20 - word at odd address becomes byte, halfword, byte cycles in order
// RULE21 - word at address ending binary 10 becomes two halfword cycles
// RULE22 - after reset seven data waits are inserted in both areas
// RULE23 - stall input sampled in T2/TW (multiplexed) or after T1/TW (separate)
// RULE24 - a wait is inserted when programmed count OR stall input asks
// RULE25 - width register bit 2n selects area n: 1 is 16-bit, 0 is 8-bit
// RULE26 - software sets the mode bit from internal memory before external access
package ebi_pkg;

   // ----------------------------------------------------------------
   // register map: word indices, byte address is four times the index
   // ----------------------------------------------------------------
   localparam logic [27:0] EBI_MODE_IDX   = 28'hfffffbe;
   localparam logic [27:0] EBI_WIDTH_IDX  = 28'hfffffbf;
   localparam logic [27:0] EBI_STALL_IDX  = 28'hfffffc0;
   localparam logic [31:0] EBI_MODE_ADDR  = {2'b00, EBI_MODE_IDX, 2'b00};
   localparam logic [31:0] EBI_WIDTH_ADDR = {2'b00, EBI_WIDTH_IDX, 2'b00};
   localparam logic [31:0] EBI_STALL_ADDR = {2'b00, EBI_STALL_IDX, 2'b00};

   // ----------------------------------------------------------------
   // reset values and field positions
   // ----------------------------------------------------------------
   localparam logic [7:0]  EBI_MODE_RST   = 8'h00;
   localparam logic [15:0] EBI_WIDTH_RST  = 16'h5555;
   localparam logic [15:0] EBI_STALL_RST  = 16'h7777;
   localparam int          EBI_SEP_BIT    = 0;
   localparam logic [1:0]  EBI_CS_NONE    = 2'b11;
   localparam logic [1:0]  EBI_CS0_ON     = 2'b10;
   localparam logic [1:0]  EBI_CS1_ON     = 2'b01;
   localparam int          EBI_AREA_BIT   = 21;
   localparam int          EBI_TOP_BIT    = 22;

   // basic clocks per access before waits
   localparam int          EBI_MUX_CLKS   = 3;
   localparam int          EBI_SEP_CLKS   = 2;

   // ----------------------------------------------------------------
   // request kinds and bus states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {EBI_TGT_EXT, EBI_TGT_ROM, EBI_TGT_RAM, EBI_TGT_PERI} ebi_tgt_t;
   typedef enum logic [1:0] {EBI_SZ_BYTE, EBI_SZ_HALF, EBI_SZ_WORD, EBI_SZ_RSVD} ebi_size_t;
   typedef enum logic [2:0] {
      EBI_IDLE = 3'b000,
      EBI_T1   = 3'b001,
      EBI_TW   = 3'b111,
      EBI_T2   = 3'b011,
      EBI_T3   = 3'b010,
      EBI_HOLD = 3'b100
   } ebi_state_t;

endpackage

/* src/ebi_bus.sv */
// external memory bus interface: APB register slave, access splitter and bus cycle sequencer
// assumes the CPU side is on clk_in and the stall and hold pins are asynchronous to it
`timescale 1ns/1ns

module ebi_bus
(
   // clock, reset, enable
   input  wire  logic                clk_in,
   input  wire  logic                sys_rst_in,
   input  wire  logic                ce_in,
   // apb slave
   input  wire  logic                psel_in,
   input  wire  logic                penable_in,
   input  wire  logic                pwrite_in,
   input  wire  logic [31:0]         paddr_in,
   input  wire  logic [31:0]         pwdata_in,
   input  wire  logic [3:0]          pstrb_in,
   output logic                      pready_out,
   output logic [31:0]               prdata_out,
   output logic                      pslverr_out,
   // cpu access port
   input  wire  logic                req_valid_in,
   input  wire  logic                req_write_in,
   input  wire  ebi_pkg::ebi_tgt_t   req_target_in,
   input  wire  ebi_pkg::ebi_size_t  req_size_in,
   input  wire  logic [25:0]         req_addr_in,
   input  wire  logic [31:0]         req_wdata_in,
   input  wire  logic [15:0]         peri_rdata_in,
   output logic                      req_ready_out,
   output logic                      ack_out,
   output logic [31:0]               rdata_out,
   // external bus pins
   input  wire  logic [15:0]         shared_addr_data_lines_in,
   output logic [15:0]               shared_addr_data_lines_out,
   output logic                      shared_addr_data_lines_oe_out,
   output logic [5:0]                upper_address_lines_out,
   output logic [15:0]               lower_address_lines_out,
   output logic [1:0]                chip_select_n_out,
   output logic [1:0]                byte_write_strobes_n_out,
   output logic                      read_strobe_n_out,
   output logic                      address_latch_strobe_out,
   input  wire  logic                stall_n_in,
   input  wire  logic                hold_request_in,
   output logic                      hold_grant_out,
   output logic                      system_clock_output_out
);
   import ebi_pkg::*;

   // ----------------------------------------------------------------
   // state of the whole block
   // ----------------------------------------------------------------
   typedef struct packed {
      ebi_state_t  st;
      logic        mode;
      logic [15:0] width;
      logic [15:0] stall_cfg;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
      logic        stall_s1;
      logic        stall_s2;
      logic        hold_s1;
      logic        hold_s2;
      logic [25:0] addr;
      logic [2:0]  left;
      logic [1:0]  done;
      logic        wr;
      ebi_tgt_t    tgt;
      logic [31:0] wdata;
      logic [31:0] rdata;
      logic [2:0]  wcnt;
      logic        half;
      logic        hi_lane;
      logic [15:0] ad;
      logic        ad_oe;
      logic [5:0]  upper;
      logic [15:0] lower;
      logic [1:0]  cs_n;
      logic [1:0]  wr_n;
      logic        rd_n;
      logic        address_latch_strobe;
      logic        hold_ack;
      logic        ack;
      logic [31:0] rdo;
      logic        ready;
   } ebi_regs_t;
   ebi_regs_t q;
   ebi_regs_t d;
   logic      need_wait;
   logic      ext_cyc;
   logic      setup;
   logic      wr_take;
   // ----------------------------------------------------------------
   // start of one bus cycle of the split access
   // ----------------------------------------------------------------
   function automatic ebi_regs_t enter_t1(ebi_regs_t r);
      logic area;
      logic wide;
      logic ext;
      area = r.addr[EBI_AREA_BIT];
      ext  = (r.tgt != EBI_TGT_PERI);
      // peripheral area is always 16 bits wide, external per area
      wide = !ext || r.width[{area, 1'b0}];                  // see RULE16 see RULE25 see RULE12 see RULE7
      // odd address or one byte left forces a byte cycle, lowest part first
      r.half    = wide && !r.addr[0] && (r.left >= 3'd2);    // see RULE17 see RULE18 see RULE19 see RULE20 see RULE21
      r.hi_lane = wide && r.addr[0];
      r.st      = EBI_T1;
      r.wcnt    = ext ? r.stall_cfg[{area, 2'b00} +: 3] : 3'd0;   // see RULE7 see RULE22
      if (ext)
      begin
         r.cs_n  = area ? EBI_CS1_ON : EBI_CS0_ON;           // see RULE6
         r.upper = r.addr[21:16];
         if (r.mode)
         begin
            // separate bus: dedicated address, strobes from T1
            r.lower = r.addr[15:0];                          // see RULE2
            r.address_latch_strobe  = 1'b0;
            r.ad    = r.half ? r.wdata[15:0] : {r.wdata[7:0], r.wdata[7:0]};
            r.ad_oe = r.wr;
            r.rd_n  = r.wr;
            r.wr_n  = !r.wr ? 2'b11 : (r.half ? 2'b00 : (r.hi_lane ? 2'b01 : 2'b10));
         end
         else
         begin
            // multiplexed: address phase on the shared lines
            r.ad    = r.addr[15:0];                          // see RULE1
            r.ad_oe = 1'b1;
            r.address_latch_strobe  = 1'b1;
         end
      end
      return r;
   endfunction
   // ----------------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------------
   assign setup     = psel_in && !penable_in;
   assign wr_take   = psel_in && penable_in && q.pready && pwrite_in;
   assign ext_cyc   = (q.tgt != EBI_TGT_PERI);
   // programmed count OR external stall, stall only for external cycles
   assign need_wait = ext_cyc && ((q.wcnt != 3'd0) || !q.stall_s2);   // see RULE24 see RULE23
   always_comb
   begin
      logic [15:0] val;
      logic [31:0] place;
      logic [2:0]  step;
      logic        finish;
      val    = 16'h0000;
      place  = 32'h0000_0000;
      step   = 3'd0;
      finish = 1'b0;
      d      = q;
      d.ack  = 1'b0;
      // pin synchronisers; data lines follow the exported clock and are sampled directly
      d.stall_s1 = stall_n_in;
      d.stall_s2 = q.stall_s1;
      d.hold_s1  = hold_request_in;
      d.hold_s2  = q.hold_s1;
      // apb: answer prepared in setup, write on the completing edge
      d.pready  = setup;
      d.pslverr = 1'b0;
      if (setup)
      begin
         d.prdata = 32'h0000_0000;
         if (paddr_in == EBI_MODE_ADDR)
            d.prdata[EBI_SEP_BIT] = q.mode;                  // see RULE8
         else if (paddr_in == EBI_WIDTH_ADDR)
            d.prdata[15:0] = q.width;
         else if (paddr_in == EBI_STALL_ADDR)
            d.prdata[15:0] = q.stall_cfg;
         else
            d.pslverr = 1'b1;
      end
      if (wr_take)
      begin
         // byte lane 0 alone is enough for the mode bit
         if (paddr_in == EBI_MODE_ADDR && pstrb_in[0])
            d.mode = pwdata_in[EBI_SEP_BIT];                 // see RULE8 see RULE9
         if (paddr_in == EBI_WIDTH_ADDR && pstrb_in[1:0] == 2'b11)
            d.width = pwdata_in[15:0];                       // see RULE13
         if (paddr_in == EBI_STALL_ADDR && pstrb_in[1:0] == 2'b11)
            d.stall_cfg = pwdata_in[15:0];
      end
      // bus cycle sequencer
      unique case (q.st)
         EBI_IDLE:
         begin
            if (q.ready && req_valid_in)
            begin
               d.addr  = req_addr_in;
               d.wr    = req_write_in;
               d.tgt   = req_target_in;
               d.wdata = req_wdata_in;
               d.rdata = 32'h0000_0000;
               d.done  = 2'd0;
               d.left  = (req_size_in == EBI_SZ_WORD) ? 3'd4 : (req_size_in == EBI_SZ_HALF) ? 3'd2 : 3'd1;
               // internal ROM/RAM reads never touch the pins
               if (req_target_in == EBI_TGT_RAM || (req_target_in == EBI_TGT_ROM && !req_write_in))
               begin
                  d.ack = 1'b1;                              // see RULE4
                  d.rdo = 32'h0000_0000;
               end
               else
                  d = enter_t1(d);                           // see RULE5
            end
            else if (q.hold_s2)
            begin
               d.st       = EBI_HOLD;
               d.hold_ack = 1'b1;
            end
         end
         EBI_T1:
         begin
            if (q.mode)
            begin
               // separate: waits sampled after T1
               if (need_wait)
               begin
                  d.st   = EBI_TW;                           // see RULE11
                  d.wcnt = (q.wcnt != 3'd0) ? q.wcnt - 3'd1 : 3'd0;
               end
               else
                  d.st = EBI_T2;
            end
            else
            begin
               // multiplexed data phase
               d.st    = EBI_T2;                             // see RULE10
               d.address_latch_strobe  = 1'b0;
               d.ad    = q.half ? q.wdata[15:0] : {q.wdata[7:0], q.wdata[7:0]};
               d.ad_oe = q.wr && ext_cyc;
               d.rd_n  = q.wr || !ext_cyc;
               d.wr_n  = (!q.wr || !ext_cyc) ? 2'b11 : (q.half ? 2'b00 : (q.hi_lane ? 2'b01 : 2'b10));
            end
         end
         EBI_T2:
         begin
            if (q.mode)
               finish = 1'b1;
            else if (need_wait)
            begin
               d.st   = EBI_TW;                              // see RULE23
               d.wcnt = (q.wcnt != 3'd0) ? q.wcnt - 3'd1 : 3'd0;
            end
            else
               d.st = EBI_T3;
         end
         EBI_TW:
         begin
            if (need_wait)
               d.wcnt = (q.wcnt != 3'd0) ? q.wcnt - 3'd1 : 3'd0;
            else
               d.st = q.mode ? EBI_T2 : EBI_T3;
         end
         EBI_T3:
            finish = 1'b1;
         EBI_HOLD:
         begin
            // bus released to another master, shared lines off and controls inactive
            if (!q.hold_s2)
            begin
               d.st       = EBI_IDLE;
               d.hold_ack = 1'b0;
            end
         end
         default:
            d.st = EBI_IDLE;
      endcase
      // end of one bus cycle: gather data, advance, next piece or done
      if (finish)
      begin
         if (!ext_cyc)
            val = q.half ? peri_rdata_in : {8'h00, peri_rdata_in[7:0]};
         else if (q.half)
            val = shared_addr_data_lines_in;
         else
            val = {8'h00, q.hi_lane ? shared_addr_data_lines_in[15:8] : shared_addr_data_lines_in[7:0]};
         place   = {16'h0000, val} << {q.done, 3'b000};      // see RULE17
         d.rdata = q.rdata | place;
         step    = q.half ? 3'd2 : 3'd1;
         d.addr  = q.addr + {23'd0, step};
         d.left  = q.left - step;
         d.done  = q.done + step[1:0];
         d.wdata = q.wdata >> {step, 3'b000};
         d.cs_n  = EBI_CS_NONE;
         d.wr_n  = 2'b11;
         d.rd_n  = 1'b1;
         d.address_latch_strobe  = 1'b0;
         d.ad_oe = 1'b0;
         if (d.left == 3'd0)
         begin
            d.st  = EBI_IDLE;
            d.ack = 1'b1;
            d.rdo = d.rdata;
         end
         else
            d = enter_t1(d);                                 // see RULE18
      end
      d.ready = (d.st == EBI_IDLE) && !d.ack;
   end
   // ----------------------------------------------------------------
   // state register, frozen while the enable is low
   // ----------------------------------------------------------------
   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         q           <= '0;
         q.st        <= EBI_IDLE;
         q.mode      <= EBI_MODE_RST[EBI_SEP_BIT];           // see RULE9
         q.width     <= EBI_WIDTH_RST;                       // see RULE13
         q.stall_cfg <= EBI_STALL_RST;                       // see RULE22
         q.stall_s1  <= 1'b1;
         q.stall_s2  <= 1'b1;
         q.cs_n      <= EBI_CS_NONE;
         q.wr_n      <= 2'b11;
         q.rd_n      <= 1'b1;
         q.tgt       <= EBI_TGT_EXT;
      end
      else if (ce_in)
         q <= d;
   end
   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign pready_out                    = q.pready;
   assign prdata_out                    = q.prdata;
   assign pslverr_out                   = q.pslverr;
   assign req_ready_out                 = q.ready;
   assign ack_out                       = q.ack;
   assign rdata_out                     = q.rdo;
   assign shared_addr_data_lines_out    = q.ad;
   assign shared_addr_data_lines_oe_out = q.ad_oe;
   assign upper_address_lines_out       = q.upper;
   assign lower_address_lines_out       = q.lower;
   assign chip_select_n_out             = q.cs_n;
   assign byte_write_strobes_n_out      = q.wr_n;
   assign read_strobe_n_out             = q.rd_n;
   assign address_latch_strobe_out      = q.address_latch_strobe;
   assign hold_grant_out                = q.hold_ack;
   // a flop cannot repeat the clock itself, so the pin carries it through
   assign system_clock_output_out       = clk_in;            // see RULE3
   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking ck @(posedge clk_in iff ce_in); endclocking
   default disable iff (sys_rst_in);
   a_cs_low_area: assert property (chip_select_n_out == EBI_CS0_ON |-> q.addr[EBI_AREA_BIT] == 1'b0) // see RULE6
      else $error("first chip select outside its area");
   a_cs_exclusive: assert property (q.cs_n != EBI_CS_NONE |-> q.cs_n != 2'b00 && !q.addr[EBI_TOP_BIT]) // see RULE6
      else $error("chip selects overlap or address above areas");
   a_no_latch_sep: assert property (q.mode |-> !address_latch_strobe_out) // see RULE2
      else $error("latch strobe in separate mode");
   a_mode_readback: assert property (setup && paddr_in == EBI_MODE_ADDR |=> prdata_out[31:1] == 31'd0) // see RULE8
      else $error("mode register upper bits not zero");
   a_mux_t1_t2: assert property (q.st == EBI_T1 && !q.mode |=> q.st == EBI_T2 && !address_latch_strobe_out) // see RULE10
      else $error("multiplexed T1 not followed by T2");
   a_sep_no_wait: assert property (q.st == EBI_T1 && q.mode && !need_wait |=> q.st == EBI_T2 ##1 q.st != EBI_T2) // see RULE11
      else $error("separate cycle not two clocks");
   a_wait_cause: assert property (q.st != EBI_TW ##1 q.st == EBI_TW |-> $past(need_wait)) // see RULE24
      else $error("wait state without cause");
   a_idle_quiet: assert property (q.st inside {EBI_IDLE, EBI_HOLD} |-> chip_select_n_out == EBI_CS_NONE && read_strobe_n_out
                                  && byte_write_strobes_n_out == 2'b11 && !shared_addr_data_lines_oe_out) // see RULE4
      else $error("controls active outside a bus cycle");
   a_odd_is_byte: assert property (q.st == EBI_T1 && q.addr[0] |-> !q.half) // see RULE19
      else $error("wide cycle at odd address");
   a_peri_quiet: assert property (q.st != EBI_IDLE && q.tgt == EBI_TGT_PERI |-> chip_select_n_out == EBI_CS_NONE) // see RULE16
      else $error("peripheral access drove a chip select");
endmodule

/* test/ebi_mem_model.sv */
// external 16-bit memory and i/o on the shared bus, behavioural
// assumes the bench resolves the shared lines and mirrors the mode bit on sep_in
`timescale 1ns/1ns
module ebi_mem_model
(
   // bus pins seen from the far side
   input  wire logic        clk_in,
   input  wire logic        sep_in,
   input  wire logic [15:0] ad_in,
   input  wire logic [5:0]  up_in,
   input  wire logic [15:0] lo_in,
   input  wire logic [1:0]  cs_n_in,
   input  wire logic [1:0]  wr_n_in,
   input  wire logic        rd_n_in,
   input  wire logic        address_latch_strobe_in,
   // read data driven back
   output logic [15:0]      ad_out
);
   logic [15:0] mem_q [0:2047];
   logic [21:0] lat_q;
   logic [15:0] last_q = 16'ha5c3;
   logic [21:0] addr;
   logic        sel;
   // ----------------------------------------
   // address select and read drive
   // ----------------------------------------
   assign addr   = sep_in ? {up_in, lo_in} : lat_q;
   assign sel    = cs_n_in != 2'b11;
   // released lines show the inverse of the last value, never a stale copy
   assign ad_out = (sel && !rd_n_in) ? mem_q[addr[11:1]] : ~last_q;
   // latch the address on the strobe, store each enabled lane
   always @(posedge clk_in)
   begin
      if (address_latch_strobe_in) lat_q <= {up_in, ad_in};
      if (sel && !rd_n_in) last_q <= ad_out;
      if (sel && !wr_n_in[0]) mem_q[addr[11:1]][7:0] <= ad_in[7:0];
      if (sel && !wr_n_in[1]) mem_q[addr[11:1]][15:8] <= ad_in[15:8];
   end
endmodule

/* test/ebi_bus_test.sv */
// self-checking bench of the external memory bus interface
// assumes ebi_pkg, ebi_bus and ebi_mem_model are compiled first
`timescale 1ns/1ns
module ebi_bus_test;
   import ebi_pkg::*;
   logic        clk_in = 0, sys_rst_in = 1, psel = 0, pen = 0, pwr = 0, rv = 0, rw = 0, hreq = 0, sep = 0, er;
   logic [31:0] pa = 0, pd = 0, rwd = 0, prd, rdat, cs_seen, prdata, rdata_o;
   logic [3:0]  ps = 0;
   logic [25:0] ra = 0;
   ebi_tgt_t    rt = EBI_TGT_EXT;
   ebi_size_t   rz = EBI_SZ_BYTE;
   logic        pready, pslverr, rrdy, ack, oe, rd_n, address_latch_strobe, hgnt, ckout, stl = 1;
   logic [15:0] ad_o, mdl, lo;
   logic [5:0]  up;
   logic [1:0]  cs_n, wr_n;
   wire  [15:0] bus = oe ? ad_o : mdl;
   int          error_cnt = 0, checks = 0, cyc = 0, address_latch_strobe_n, t, tb1, th, t7;

   always #10 clk_in = ~clk_in;

   ebi_bus dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .ce_in(1'b1),
      .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pd), .pstrb_in(ps),
      .pready_out(pready), .prdata_out(prdata), .pslverr_out(pslverr),
      .req_valid_in(rv), .req_write_in(rw), .req_target_in(rt), .req_size_in(rz), .req_addr_in(ra),
      .req_wdata_in(rwd), .peri_rdata_in(16'h1234), .req_ready_out(rrdy), .ack_out(ack), .rdata_out(rdata_o),
      .shared_addr_data_lines_in(bus), .shared_addr_data_lines_out(ad_o), .shared_addr_data_lines_oe_out(oe),
      .upper_address_lines_out(up), .lower_address_lines_out(lo), .chip_select_n_out(cs_n),
      .byte_write_strobes_n_out(wr_n), .read_strobe_n_out(rd_n), .address_latch_strobe_out(address_latch_strobe),
      .stall_n_in(stl), .hold_request_in(hreq), .hold_grant_out(hgnt), .system_clock_output_out(ckout));

   ebi_mem_model mdl_i (.clk_in(clk_in), .sep_in(sep), .ad_in(bus), .up_in(up), .lo_in(lo), .cs_n_in(cs_n),
      .wr_n_in(wr_n), .rd_n_in(rd_n), .address_latch_strobe_in(address_latch_strobe), .ad_out(mdl));

   // ----------------------------------------
   // pin monitor and hang guard
   // ----------------------------------------
   always @(posedge clk_in)
   begin
      cs_seen = cs_seen | {30'h0, ~cs_n};
      address_latch_strobe_n += address_latch_strobe;
      cyc++;
      if (cyc == 5000)
      begin
         error_cnt++;
         wrap_up();
      end
   end

   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e)
      begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   // apb: setup, access until pready, release only after it
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge clk_in);
      psel <= 1; pen <= 0; pwr <= w; pa <= a; pd <= d; ps <= s;
      @(posedge clk_in);
      pen <= 1;
      do @(posedge clk_in); while (pready !== 1'b1);
      prd = prdata; er = pslverr;
      psel <= 0; pen <= 0;
   endtask

   // cpu access; t counts edges from taking to the ack edge
   task automatic cpu(input logic w, input ebi_tgt_t g, input ebi_size_t z, input logic [25:0] a,
                      input logic [31:0] d);
      @(posedge clk_in);
      rv <= 1; rw <= w; rt <= g; rz <= z; ra <= a; rwd <= d;
      cs_seen = 0; address_latch_strobe_n = 0;
      do @(posedge clk_in); while (rrdy !== 1'b1);
      rv <= 0; t = 0;
      do begin @(posedge clk_in); t++; end while (ack !== 1'b1);
      rdat = rdata_o;
   endtask

   task automatic wrap_up;
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // ----------------------------------------
   // test sequence
   // ----------------------------------------
   initial
   begin
      repeat (20) @(posedge clk_in);
      sys_rst_in <= 0;
      apb(0, EBI_MODE_ADDR, 32'h0, 4'h0); chk(prd, 32'h0);
      apb(0, EBI_WIDTH_ADDR, 32'h0, 4'h0); chk(prd, 32'h5555);
      apb(0, 32'h0, 32'h0, 4'h0); chk({31'h0, er}, 32'h1);
      apb(1, EBI_WIDTH_ADDR, 32'h5551, 4'h3);
      apb(0, EBI_WIDTH_ADDR, 32'h0, 4'h0); chk(prd, 32'h5551);
      $display("test registers done");
      // area 0 first at seven waits, then two; area 1 at none
      cpu(0, EBI_TGT_EXT, EBI_SZ_HALF, 26'h100, 32'h0); t7 = t;
      apb(1, EBI_STALL_ADDR, 32'h0002, 4'h3);
      cpu(1, EBI_TGT_EXT, EBI_SZ_BYTE, 26'h200004, 32'h11); tb1 = t;
      chk(tb1, 32'd4);
      chk(cs_seen, 32'h2);
      cpu(1, EBI_TGT_EXT, EBI_SZ_BYTE, 26'h1fffff, 32'h22); chk(cs_seen, 32'h1);
      chk(address_latch_strobe_n, 32'd1);
      cpu(1, EBI_TGT_EXT, EBI_SZ_HALF, 26'h100, 32'hbeef); th = t;
      chk(th, tb1 + 2);
      chk(t7, th + 5);
      cpu(0, EBI_TGT_EXT, EBI_SZ_HALF, 26'h100, 32'h0); chk({16'h0, rdat[15:0]}, 32'hbeef);
      cpu(0, EBI_TGT_EXT, EBI_SZ_HALF, 26'h200100, 32'h0); chk(t, tb1 + 3);
      $display("test areas and waits done");
      cpu(1, EBI_TGT_EXT, EBI_SZ_HALF, 26'h201, 32'ha55a); chk(t, th + 5);
      cpu(0, EBI_TGT_EXT, EBI_SZ_HALF, 26'h201, 32'h0); chk({16'h0, rdat[15:0]}, 32'ha55a);
      cpu(1, EBI_TGT_EXT, EBI_SZ_WORD, 26'h301, 32'h12345678); chk(t, th + 10);
      cpu(0, EBI_TGT_EXT, EBI_SZ_BYTE, 26'h302, 32'h0); chk({24'h0, rdat[7:0]}, 32'h56);
      cpu(0, EBI_TGT_EXT, EBI_SZ_WORD, 26'h301, 32'h0); chk(rdat, 32'h12345678);
      cpu(1, EBI_TGT_EXT, EBI_SZ_WORD, 26'h402, 32'hcafef00d); chk(t, th + 5);
      cpu(0, EBI_TGT_EXT, EBI_SZ_WORD, 26'h402, 32'h0); chk(rdat, 32'hcafef00d);
      $display("test split accesses done");
      cpu(0, EBI_TGT_RAM, EBI_SZ_WORD, 26'h100, 32'h0); chk(cs_seen | address_latch_strobe_n, 32'h0);
      cpu(0, EBI_TGT_PERI, EBI_SZ_WORD, 26'h10, 32'h0); chk(rdat, 32'h12341234);
      chk(t, tb1 + 3);
      chk(cs_seen, 32'h0);
      cpu(1, EBI_TGT_ROM, EBI_SZ_HALF, 26'h500, 32'h5a5a); chk(cs_seen, 32'h1);
      cpu(0, EBI_TGT_EXT, EBI_SZ_HALF, 26'h500, 32'h0); chk({16'h0, rdat[15:0]}, 32'h5a5a);
      $display("test internal targets done");
      apb(1, EBI_MODE_ADDR, 32'hff, 4'h1); sep <= 1;
      apb(0, EBI_MODE_ADDR, 32'h0, 4'h0); chk(prd, 32'h1);
      cpu(1, EBI_TGT_EXT, EBI_SZ_BYTE, 26'h200008, 32'h33); chk(t, tb1 - 1);
      cpu(1, EBI_TGT_EXT, EBI_SZ_HALF, 26'h600, 32'h7e81); chk(address_latch_strobe_n, 32'h0);
      cpu(0, EBI_TGT_EXT, EBI_SZ_HALF, 26'h600, 32'h0); chk({16'h0, rdat[15:0]}, 32'h7e81);
      apb(1, EBI_MODE_ADDR, 32'h0, 4'h1); sep <= 0;
      $display("test separate mode done");
      // stall pin low on a no-wait area: waits follow the synchronised pin, two clocks late
      stl <= 0;
      fork
         cpu(1, EBI_TGT_EXT, EBI_SZ_BYTE, 26'h200010, 32'h44);
         begin
            repeat (6) @(posedge clk_in);
            stl <= 1;
         end
      join
      chk(t, tb1 + 5);
      @(negedge clk_in); #1 chk({31'h0, ckout}, 32'h0);
      @(posedge clk_in); #1 chk({31'h0, ckout}, 32'h1);
      @(posedge clk_in); hreq <= 1;
      repeat (8) @(posedge clk_in);
      chk({30'h0, hgnt, rrdy}, 32'h2);
      hreq <= 0;
      repeat (8) @(posedge clk_in);
      chk({31'h0, hgnt}, 32'h0);
      $display("test clock and hold done");
      wrap_up();
   end
endmodule
